// *** dv/mcp_gate_drv.sv ***
// Gate driver and safety pin model
`timescale 1ns/1ps
module mcp_gate_drv (
	input wire sys_clk_i,
	input wire [2:0] high_i,
	input wire [2:0] low_i,
	input wire fault_req_i,
	output wire safety_o,
	output reg shoot_o
);
	// Pulled down unless the stage reports a fault
	assign safety_o = fault_req_i;
	initial shoot_o = 1'b0;
	always @(posedge sys_clk_i) begin
		if (|(high_i & low_i))
			shoot_o <= 1'b1;
	end
endmodule

// *** dv/mcp_pwm_asserts.sv ***
// Port checker for the motor PWM unit
`timescale 1ns/1ps
module mcp_pwm_asserts (
	input wire sys_clk_i,
	input wire sys_rst_i,
	input wire [5:0] addr_i,
	input wire wr_i,
	input wire rd_i,
	input wire [15:0] rdata_o,
	input wire safety_fault_in_i,
	input wire [2:0] pwm_high_out_o,
	input wire [2:0] pwm_low_out_o,
	input wire [2:0] adc_trig_o,
	input wire adc_sevt_o,
	input wire sync_out_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);
	// Pin high long enough to pass the input path, no reprogramming
	sequence s_pin_held;
		safety_fault_in_i[*2] ##1 (safety_fault_in_i && !wr_i)[*4];
	endsequence
	AST_PAIR: assert property (!(pwm_high_out_o & pwm_low_out_o))
		else $error("both sides of a pair on");
	AST_RST_QUIET: assert property ($fell(sys_rst_i) |->
		(pwm_high_out_o == 3'h0 && pwm_low_out_o == 3'h0)[*2]) else $error("outputs on at reset");
	AST_SAFE_HOLD: assert property (s_pin_held |=>
		$stable(pwm_high_out_o) && $stable(pwm_low_out_o)) else $error("outputs move in fault");
	AST_TRIG_PULSE: assert property ((adc_trig_o & $past(adc_trig_o)) == 3'h0)
		else $error("trigger longer than one cycle");
	AST_SEVT_PULSE: assert property (adc_sevt_o |=> !adc_sevt_o)
		else $error("event trigger too long");
	AST_SYNC_PULSE: assert property (sync_out_o |=> !sync_out_o)
		else $error("sync out too long");
	AST_RD_IDLE: assert property (!rd_i |=> rdata_o == 16'h0000)
		else $error("read data outside read");
	AST_RD_HOLE: assert property (rd_i && addr_i == 6'h3f |=> rdata_o == 16'h0000)
		else $error("unmapped read not zero");
endmodule
bind mcp_pwm mcp_pwm_asserts chk (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
	.addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
	.safety_fault_in_i(safety_fault_in_i), .pwm_high_out_o(pwm_high_out_o),
	.pwm_low_out_o(pwm_low_out_o), .adc_trig_o(adc_trig_o), .adc_sevt_o(adc_sevt_o),
	.sync_out_o(sync_out_o));

// *** dv/multi_channel_motor_pwm_test.sv ***
// Bench for the motor PWM unit
`timescale 1ns/1ps
`include "mcp_consts.vh"
module multi_channel_motor_pwm_test;
	reg clk = 1'b0;
	reg rst = 1'b1;
	reg [5:0] a = 6'h00;
	reg [15:0] wd = 16'h0000;
	reg wr = 1'b0;
	reg rd = 1'b0;
	reg req = 1'b0;
	reg fa = 1'b0;
	reg fb = 1'b0;
	reg si = 1'b0;
	wire pin, sh, se, so;
	wire [15:0] rdo;
	wire [2:0] hi, lo, tr;
	wire [4:0] w = {se, so, tr[0], lo[0], hi[0]};
	integer n_mismatch = 0;
	integer checks_done = 0;
	integer i;
	reg [15:0] rv;
	reg [21:0] rows [0:3];
	always #2 clk = ~clk;
	mcp_pwm dut (.sys_clk_i(clk), .sys_rst_i(rst), .addr_i(a), .wdata_i(wd), .wr_i(wr),
		.rd_i(rd), .rdata_o(rdo), .sync_in_i(si), .fault_in_a_i(fa), .fault_in_b_i(fb),
		.safety_fault_in_i(pin), .pwm_high_out_o(hi), .pwm_low_out_o(lo), .adc_trig_o(tr),
		.adc_sevt_o(se), .sync_out_o(so));
	mcp_gate_drv gate (.sys_clk_i(clk), .high_i(hi), .low_i(lo), .fault_req_i(req),
		.safety_o(pin), .shoot_o(sh));
	task give_verdict;
		begin
			$display("checks %0d mismatches %0d", checks_done, n_mismatch);
			if (n_mismatch == 0 && checks_done > 0)
				$display("*** PASS ***");
			else
				$display("*** FAIL ***");
			$finish;
		end
	endtask
	task check(input [15:0] seen, input [15:0] exp);
		begin
			checks_done = checks_done + 1;
			if (seen !== exp) begin
				n_mismatch = n_mismatch + 1;
				$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
			end
		end
	endtask
	task wreg(input [5:0] ad, input [15:0] d);
		begin
			@(posedge clk);
			a <= ad;
			wd <= d;
			wr <= 1'b1;
			@(posedge clk);
			wr <= 1'b0;
		end
	endtask
	task rreg(input [5:0] ad);
		begin
			@(posedge clk);
			a <= ad;
			rd <= 1'b1;
			@(posedge clk);
			rd <= 1'b0;
			#1 rv = rdo;
		end
	endtask
	task await(input integer s);
		integer k;
		begin
			k = 0;
			while (w[s] !== 1'b1 && k < 600) begin
				@(posedge clk);
				#1 k = k + 1;
			end
			if (k == 600) begin
				n_mismatch = n_mismatch + 1;
				give_verdict;
			end
		end
	endtask
	initial begin
		rows[0] = {`MCP_A_CTRL, 16'h0000};
		rows[1] = {`MCP_A_MPER, `MCP_PER_RST};
		rows[2] = {`MCP_A_FLT, 16'h0000};
		rows[3] = {6'h3f, 16'h0000};
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		for (i = 0; i < 4; i = i + 1) begin
			rreg(rows[i][21:16]);
			check(rv, rows[i][15:0]);
		end
		$display("reset rows done");
		rreg(`MCP_A_STAT);
		check(rv & 16'h0008, 16'h0008);
		req <= 1'b1;
		wreg(`MCP_A_FLT, 16'h0005);
		rreg(`MCP_A_FLT);
		check(rv, 16'h0001);
		rreg(`MCP_A_STAT);
		check(rv & 16'h0008, 16'h0008);
		wreg(`MCP_A_FLT, 16'h0000);
		req <= 1'b0;
		repeat (4) @(posedge clk);
		wreg(`MCP_A_FLT, 16'h0004);
		rreg(`MCP_A_STAT);
		check(rv & 16'h0008, 16'h0000);
		$display("safety latch done");
		wreg(6'h08, 16'h0010);
		wreg(6'h09, 16'h0008);
		wreg(6'h0c, 16'h0002);
		wreg(`MCP_A_MPER, 16'h0010);
		wreg(`MCP_A_CTRL, 16'h0001);
		await(0);
		await(1);
		await(2);
		await(3);
		req <= 1'b1;
		repeat (6) @(posedge clk);
		req <= 1'b0;
		rv = 16'h0000;
		repeat (40) begin
			@(posedge clk);
			#1 rv = rv | {10'h000, hi, lo};
		end
		check(rv, 16'h0000);
		wreg(`MCP_A_FLT, 16'h0004);
		await(0);
		check({15'h0000, sh}, 16'h0000);
		$display("modulation and fault done");
		await(4);
		check({15'h0000, se}, 16'h0001);
		repeat (20) @(posedge clk);
		#1 await(2);
		check({14'h0000, hi[0], lo[0]}, 16'h0002);
		wreg(6'h0d, 16'h0001);
		repeat (20) @(posedge clk);
		#1 await(2);
		check({14'h0000, hi[0], lo[0]}, 16'h0001);
		wreg(6'h0d, 16'h0000);
		$display("swap and event trigger done");
		wreg(`MCP_A_CTRL, 16'h0003);
		#1 await(3);
		repeat (5) @(posedge clk);
		si <= 1'b1;
		@(posedge clk);
		si <= 1'b0;
		#1 check({15'h0000, so}, 16'h0001);
		$display("sync input done");
		wreg(`MCP_A_CTRL, 16'h0019);
		fa <= 1'b1;
		fb <= 1'b1;
		repeat (3) @(posedge clk);
		fa <= 1'b0;
		fb <= 1'b0;
		rv = 16'h0000;
		repeat (20) begin
			@(posedge clk);
			#1 rv = rv | {10'h000, hi, lo};
		end
		check(rv, 16'h0000);
		rreg(`MCP_A_STAT);
		check(rv & 16'h0030, 16'h0030);
		wreg(`MCP_A_FLT, 16'h0004);
		rreg(`MCP_A_STAT);
		check(rv & 16'h0030, 16'h0000);
		#1 await(0);
		$display("general faults done");
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		#1 check({10'h000, hi, lo}, 16'h0000);
		rreg(`MCP_A_STAT);
		check(rv & 16'h0008, 16'h0008);
		rreg(`MCP_A_FLT);
		check(rv, 16'h0000);
		rreg(`MCP_A_MPER);
		check(rv, `MCP_PER_RST);
		$display("second reset done");
		give_verdict;
	end
endmodule

// *** hw/mcp_consts.vh ***
// Constants for the multi-channel motor PWM unit
`ifndef MCP_CONSTS_VH
`define MCP_CONSTS_VH
`define MCP_NGEN 3
`define MCP_AW 6
`define MCP_DW 16
`define MCP_CLK_MHZ 250
`define MCP_A_CTRL 6'h00
`define MCP_A_MPER 6'h01
`define MCP_A_FLT 6'h02
`define MCP_A_STAT 6'h03
`define MCP_A_SEVT 6'h04
`define MCP_A_SPER 6'h05
`define MCP_A_GBASE 6'h08
`define MCP_G_STRIDE 8
`define MCP_G_PER 3'h0
`define MCP_G_DUTY 3'h1
`define MCP_G_PHASE 3'h2
`define MCP_G_DEAD 3'h3
`define MCP_G_TRIG 3'h4
`define MCP_G_CON 3'h5
`define MCP_C_EN 0
`define MCP_C_SYNCIN_EN 1
`define MCP_C_SEVT_SEL 2
`define MCP_C_FLTA_EN 3
`define MCP_C_FLTB_EN 4
`define MCP_GC_SWAP 0
`define MCP_GC_MASTER 1
`define MCP_GC_SAFE_H 2
`define MCP_GC_SAFE_L 3
`define MCP_FM_LATCH 2'h0
`define MCP_FM_CYCLE 2'h1
`define MCP_FM_OFF 2'h3
`define MCP_F_CLEAR 2
`define MCP_FLT_RST 2'h0
`define MCP_PER_RST 16'h00ff
`endif

// *** hw/mcp_pwm.v ***
// Three-generator complementary PWM unit with fault protection
//
// Chosen here: strobed register access and the register offsets.
`timescale 1ns/1ps
`include "mcp_consts.vh"

// Function
// - Three generators, six modulated outputs
// - Each generator drives complementary high/low pair
// - Per-generator period, duty, phase independently programmable
// - Master time base aligns all generators
// - Resolution is one system clock step
// - Enabled asserted faults force safe state
// - Per-generator ADC trigger at programmed count
// - Special event trigger from selectable time base
// - Sync input restarts master time base
// - Sync output pulses at master rollover
// - Remapped fault inputs plus fixed safety input
// - Safety fault stays owned through reset
// - Safety fault resets enabled, latched mode
// - Latched clear works only while pin low
// - Fault mode writable regardless of pin
// - High/low pin roles swappable per pair
module mcp_pwm (
	input wire sys_clk_i,
	input wire sys_rst_i,
	input wire [5:0] addr_i,
	input wire [15:0] wdata_i,
	input wire wr_i,
	input wire rd_i,
	output reg [15:0] rdata_o,
	input wire sync_in_i,
	input wire fault_in_a_i,
	input wire fault_in_b_i,
	input wire safety_fault_in_i,
	output reg [2:0] pwm_high_out_o,
	output reg [2:0] pwm_low_out_o,
	output reg [2:0] adc_trig_o,
	output reg adc_sevt_o,
	output reg sync_out_o
);
	function is_gen_reg;
		input [5:0] a;
		input [2:0] g;
		input [2:0] r;
		begin
			is_gen_reg = (a == (`MCP_A_GBASE + g * `MCP_G_STRIDE + r));
		end
	endfunction

	reg [4:0] ctrl_reg;
	reg [15:0] mper_reg;
	reg [15:0] sper_reg;
	reg [15:0] sevt_reg;
	reg [15:0] mcnt_reg;
	reg [15:0] scnt_reg;
	reg [1:0] fmode_reg;
	reg slatch_reg;
	reg alatch_reg;
	reg blatch_reg;
	reg [15:0] per_reg [0:2];
	reg [15:0] duty_reg [0:2];
	reg [15:0] phase_reg [0:2];
	reg [15:0] dead_reg [0:2];
	reg [15:0] trig_reg [0:2];
	reg [3:0] gcon_reg [0:2];
	reg [15:0] gcnt_reg [0:2];
	reg [2:0] raw_reg;
	reg [15:0] dcnt_reg [0:2];

	wire msync = ctrl_reg[`MCP_C_SYNCIN_EN] && sync_in_i;
	wire mroll = (mcnt_reg >= mper_reg) || msync;
	wire sroll = (scnt_reg >= sper_reg);
	wire clr_wr = wr_i && (addr_i == `MCP_A_FLT) && wdata_i[`MCP_F_CLEAR];
	// Fault pin level gates the clear, not the mode write
	wire sclr_ok = clr_wr && !safety_fault_in_i;
	wire s_active = (fmode_reg != `MCP_FM_OFF) &&
		(safety_fault_in_i || (fmode_reg == `MCP_FM_LATCH && slatch_reg));
	wire a_active = ctrl_reg[`MCP_C_FLTA_EN] && (fault_in_a_i || alatch_reg);
	wire b_active = ctrl_reg[`MCP_C_FLTB_EN] && (fault_in_b_i || blatch_reg);
	wire any_fault = s_active || a_active || b_active;

	// Master and secondary time bases
	always @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			mcnt_reg <= 16'h0000;
			scnt_reg <= 16'h0000;
		end else begin
			mcnt_reg <= mroll ? 16'h0000 : mcnt_reg + 16'h0001;
			scnt_reg <= sroll ? 16'h0000 : scnt_reg + 16'h0001;
		end
	end

	// Fault latches; a new fault wins over a clear
	always @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			fmode_reg <= `MCP_FLT_RST;
			slatch_reg <= 1'b1;
			alatch_reg <= 1'b0;
			blatch_reg <= 1'b0;
		end else begin
			if (wr_i && addr_i == `MCP_A_FLT) begin
				fmode_reg <= wdata_i[1:0];
			end
			if (safety_fault_in_i && fmode_reg == `MCP_FM_LATCH) begin
				slatch_reg <= 1'b1;
			end else if (sclr_ok) begin
				slatch_reg <= 1'b0;
			end
			if (ctrl_reg[`MCP_C_FLTA_EN] && fault_in_a_i) begin
				alatch_reg <= 1'b1;
			end else if (clr_wr) begin
				alatch_reg <= 1'b0;
			end
			if (ctrl_reg[`MCP_C_FLTB_EN] && fault_in_b_i) begin
				blatch_reg <= 1'b1;
			end else if (clr_wr) begin
				blatch_reg <= 1'b0;
			end
		end
	end

	// Global registers and read port
	always @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			ctrl_reg <= 5'h00;
			mper_reg <= `MCP_PER_RST;
			sper_reg <= `MCP_PER_RST;
			sevt_reg <= 16'h0000;
			rdata_o <= 16'h0000;
		end else begin
			if (wr_i) begin
				case (addr_i)
					`MCP_A_CTRL: begin
						ctrl_reg <= wdata_i[4:0];
					end
					`MCP_A_MPER: begin
						mper_reg <= wdata_i;
					end
					`MCP_A_SPER: begin
						sper_reg <= wdata_i;
					end
					`MCP_A_SEVT: begin
						sevt_reg <= wdata_i;
					end
					default: ;
				endcase
			end
			rdata_o <= 16'h0000;
			if (rd_i) begin
				case (addr_i)
					`MCP_A_CTRL: begin
						rdata_o <= {11'h000, ctrl_reg};
					end
					`MCP_A_MPER: begin
						rdata_o <= mper_reg;
					end
					`MCP_A_FLT: begin
						rdata_o <= {14'h0000, fmode_reg};
					end
					`MCP_A_STAT: begin
						rdata_o <= {9'h000, safety_fault_in_i, blatch_reg,
							alatch_reg, slatch_reg, s_active, a_active, b_active};
					end
					`MCP_A_SEVT: begin
						rdata_o <= sevt_reg;
					end
					`MCP_A_SPER: begin
						rdata_o <= sper_reg;
					end
					default: rdata_o <= gen_rd(addr_i);
				endcase
			end
		end
	end

	function [15:0] gen_rd;
		input [5:0] a;
		integer k;
		begin
			gen_rd = 16'h0000;
			for (k = 0; k < `MCP_NGEN; k = k + 1) begin
				if (is_gen_reg(a, k[2:0], `MCP_G_PER)) begin
					gen_rd = per_reg[k];
				end
				if (is_gen_reg(a, k[2:0], `MCP_G_DUTY)) begin
					gen_rd = duty_reg[k];
				end
				if (is_gen_reg(a, k[2:0], `MCP_G_PHASE)) begin
					gen_rd = phase_reg[k];
				end
				if (is_gen_reg(a, k[2:0], `MCP_G_DEAD)) begin
					gen_rd = dead_reg[k];
				end
				if (is_gen_reg(a, k[2:0], `MCP_G_TRIG)) begin
					gen_rd = trig_reg[k];
				end
				if (is_gen_reg(a, k[2:0], `MCP_G_CON)) begin
					gen_rd = {12'h000, gcon_reg[k]};
				end
			end
		end
	endfunction

	// Special event trigger and sync output
	always @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			adc_sevt_o <= 1'b0;
			sync_out_o <= 1'b0;
		end else begin
			if (ctrl_reg[`MCP_C_SEVT_SEL]) begin
				adc_sevt_o <= (scnt_reg == sevt_reg);
			end else begin
				adc_sevt_o <= (mcnt_reg == sevt_reg);
			end
			sync_out_o <= mroll;
		end
	end

	genvar g;
	generate
		for (g = 0; g < `MCP_NGEN; g = g + 1) begin : gen_pwm
			localparam [2:0] gen_idx = g;
			wire [15:0] gper = gcon_reg[g][`MCP_GC_MASTER] ? mper_reg : per_reg[g];
			wire groll = (gcnt_reg[g] >= gper);
			wire raw = (gcnt_reg[g] < duty_reg[g]);
			wire dt_done = (dcnt_reg[g] >= dead_reg[g]);
			wire hi = raw && raw_reg[g] && dt_done;
			wire lo = !raw && !raw_reg[g] && dt_done;
			wire en = ctrl_reg[`MCP_C_EN];
			wire sw = gcon_reg[g][`MCP_GC_SWAP];
			always @(posedge sys_clk_i) begin
				if (sys_rst_i) begin
					per_reg[g] <= `MCP_PER_RST;
					duty_reg[g] <= 16'h0000;
					phase_reg[g] <= 16'h0000;
					dead_reg[g] <= 16'h0000;
					trig_reg[g] <= 16'h0000;
					gcon_reg[g] <= 4'h0;
					gcnt_reg[g] <= 16'h0000;
					dcnt_reg[g] <= 16'h0000;
					raw_reg[g] <= 1'b0;
					pwm_high_out_o[g] <= 1'b0;
					pwm_low_out_o[g] <= 1'b0;
					adc_trig_o[g] <= 1'b0;
				end else begin
					// Settings of one generator never touch the others
					if (wr_i) begin
						if (is_gen_reg(addr_i, gen_idx, `MCP_G_PER)) begin
							per_reg[g] <= wdata_i;
						end
						if (is_gen_reg(addr_i, gen_idx, `MCP_G_DUTY)) begin
							duty_reg[g] <= wdata_i;
						end
						if (is_gen_reg(addr_i, gen_idx, `MCP_G_PHASE)) begin
							phase_reg[g] <= wdata_i;
						end
						if (is_gen_reg(addr_i, gen_idx, `MCP_G_DEAD)) begin
							dead_reg[g] <= wdata_i;
						end
						if (is_gen_reg(addr_i, gen_idx, `MCP_G_TRIG)) begin
							trig_reg[g] <= wdata_i;
						end
						if (is_gen_reg(addr_i, gen_idx, `MCP_G_CON)) begin
							gcon_reg[g] <= wdata_i[3:0];
						end
					end
					// Master rollover reloads phase offset
					if (mroll) begin
						gcnt_reg[g] <= phase_reg[g];
					end else if (groll) begin
						gcnt_reg[g] <= 16'h0000;
					end else begin
						gcnt_reg[g] <= gcnt_reg[g] + 16'h0001;
					end
					raw_reg[g] <= raw;
					// Dead time restarts at every raw edge
					if (raw != raw_reg[g]) begin
						dcnt_reg[g] <= 16'h0000;
					end else if (!dt_done) begin
						dcnt_reg[g] <= dcnt_reg[g] + 16'h0001;
					end
					adc_trig_o[g] <= en && (gcnt_reg[g] == trig_reg[g]);
					if (!en || any_fault) begin
						// Software clears latched faults first; outputs then follow enable
						pwm_high_out_o[g] <= en && gcon_reg[g][`MCP_GC_SAFE_H];
						pwm_low_out_o[g] <= en && gcon_reg[g][`MCP_GC_SAFE_L];
					end else begin
						pwm_high_out_o[g] <= sw ? lo : hi;
						pwm_low_out_o[g] <= sw ? hi : lo;
					end
				end
			end
		end
	endgenerate
endmodule
